// ---- logic/rtcsa_pkg.sv ----
// constants, register map and carrier types of the seconds/subsecond real-time clock
package rtcsa_pkg;

	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] OFS_SECONDS  = 8'h00;
	localparam logic [7:0] OFS_SUBSEC   = 8'h04;
	localparam logic [7:0] OFS_TOD_ALM  = 8'h08;
	localparam logic [7:0] OFS_SS_ALM   = 8'h0C;
	localparam logic [7:0] OFS_CTRL     = 8'h10;
	localparam logic [7:0] OFS_CAL      = 8'h14;
	localparam logic [7:0] OFS_STATUS   = 8'h18;
	localparam logic [7:0] OFS_INT_CLR  = 8'h1C;
	localparam logic [7:0] OFS_INT_EN   = 8'h20;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_RUN       = 0;
	localparam int CTRL_TOD_EN    = 1;
	localparam int CTRL_SS_EN     = 2;
	localparam int CTRL_TOD_RECUR = 3;
	localparam int CTRL_SS_RECUR  = 4;
	localparam int CTRL_SQW_EN    = 5;
	localparam int CTRL_W         = 6;
	localparam int ST_TOD         = 0;
	localparam int ST_SS          = 1;
	localparam int ST_BAD_ALM     = 2;
	localparam int ST_W           = 3;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h01;
	localparam logic [7:0]        CAL_RST  = 8'h00;
	localparam logic [ST_W-1:0]   IEN_RST  = 3'h0;

	// ************************************************************
	// time base figures
	// ************************************************************
	localparam int SUB_W          = 12;         // 4096 subsecond ticks per second
	localparam int XTAL_PER_SUB   = 8;          // 32768 / 4096
	localparam int DIV_W          = 3;
	localparam int PPM_FULL       = 1000000;    // one part per million unit
	localparam int ACC_W          = 20;
	localparam int ALM_MIN_S      = 1;          // nearest alarm, seconds ahead
	localparam int ALM_MAX_DAYS   = 12;
	localparam int ALM_MAX_S      = ALM_MAX_DAYS * 24 * 3600;
	localparam logic [ACC_W-1:0]  ACC_FULL = ACC_W'(PPM_FULL);

	// ************************************************************
	// carrier types
	// ************************************************************
	typedef enum logic [1:0] {
		RTCSA_ACTIVE,
		RTCSA_SLEEP,
		RTCSA_DEEPSLEEP,
		RTCSA_BACKUP
	} rtcsa_pmode_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} rtcsa_bus_t;

	// sticky status merge: a set in the same cycle as its clear wins
	function automatic logic [ST_W-1:0] sticky(input logic [ST_W-1:0] cur,
	                                           input logic [ST_W-1:0] set,
	                                           input logic [ST_W-1:0] clr);
		sticky = (cur & ~clr) | set;
	endfunction : sticky

endpackage : rtcsa_pkg

// ---- logic/rtcsa_prescale.sv ----
// 32.768 kHz edge divider with ppm trim and square-wave source
`timescale 1ns/1ps
module rtcsa_prescale
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       ce,
	// time base and trim
	input  wire logic       xtal_in,
	input  wire logic [7:0] cal,
	input  wire logic       sqw_en,
	// results
	output logic            tick,
	output logic            sqw
);

	typedef struct packed {
		logic                            xtal_d;
		logic [rtcsa_pkg::DIV_W-1:0]     div;
		logic [rtcsa_pkg::ACC_W-1:0]     acc;
		logic                            tick;
		logic                            sqw;
	} rtcsa_pre_t;

	rtcsa_pre_t st_r;
	rtcsa_pre_t st_nxt;

	// ************************************************************
	// trim: the ppm accumulator adds or swallows one crystal edge
	// ************************************************************
	always_comb
	begin
		logic [rtcsa_pkg::ACC_W-1:0] mag;
		logic [rtcsa_pkg::DIV_W:0]   sum;
		logic [1:0]                  step;
		mag    = '0;
		sum    = '0;
		step   = 2'h1;
		st_nxt = st_r;
		st_nxt.xtal_d = xtal_in;
		st_nxt.tick   = 1'b0;
		mag = rtcsa_pkg::ACC_W'(cal[7] ? 8'(-cal) : cal);
		if (xtal_in && !st_r.xtal_d)
		begin
			st_nxt.acc = st_r.acc + mag;
			// one extra or missing edge per million keeps the ppm step exact
			if (st_nxt.acc >= rtcsa_pkg::ACC_FULL)
			begin
				st_nxt.acc = st_nxt.acc - rtcsa_pkg::ACC_FULL;
				step = cal[7] ? 2'h0 : 2'h2;
			end
			sum = {1'b0, st_r.div} + {2'h0, step};
			st_nxt.div  = sum[rtcsa_pkg::DIV_W-1:0];
			st_nxt.tick = sum[rtcsa_pkg::DIV_W];
		end
		st_nxt.sqw = sqw_en & st_nxt.div[rtcsa_pkg::DIV_W-1];
	end

	// state register, frozen while ce is low
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	assign tick = st_r.tick;
	assign sqw  = st_r.sqw;

endmodule : rtcsa_prescale

// ---- logic/rtcsa_top.sv ----
// seconds counter real-time clock with time-of-day and subsecond alarms
// ************************************************************
// ************************************************************
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module rtcsa_top
(
	// clock, reset and enable
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic                    ce,
	// register port
	input  wire rtcsa_pkg::rtcsa_bus_t   bus,
	output logic [31:0]                  rdata,
	// time base and power state
	input  wire logic                    xtal_in,
	input  wire rtcsa_pkg::rtcsa_pmode_t pmode,
	// events and pins
	output logic                         irq,
	output logic                         wake_req,
	output logic                         square_wave_output
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [31:0]                     sec;
		logic [rtcsa_pkg::SUB_W-1:0]     sub;
		logic [31:0]                     tod_match;
		logic [31:0]                     tod_int;
		logic                            tod_arm;
		logic [31:0]                     ss_reload;
		logic [31:0]                     ss_cnt;
		logic                            ss_arm;
		logic [rtcsa_pkg::CTRL_W-1:0]    ctrl;
		logic [7:0]                      cal;
		logic [rtcsa_pkg::ST_W-1:0]      stat;
		logic [rtcsa_pkg::ST_W-1:0]      ien;
		logic [31:0]                     rdata;
		logic                            irq;
		logic                            wake;
	} rtcsa_state_t;

	rtcsa_state_t st_r;
	rtcsa_state_t st_nxt;

	logic tick;
	logic sqw;

	// ************************************************************
	// time base
	// ************************************************************
	rtcsa_prescale u_pre
	(
		.mclk    (mclk),
		.rst     (rst),
		.ce      (ce),
		.xtal_in (xtal_in),
		.cal     (st_r.cal),
		.sqw_en  (st_r.ctrl[rtcsa_pkg::CTRL_SQW_EN]),
		.tick    (tick),
		.sqw     (sqw)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		logic [rtcsa_pkg::ST_W-1:0] set;
		logic [rtcsa_pkg::ST_W-1:0] clr;
		logic                       wr;
		logic                       run;
		logic                       sec_step;
		logic [31:0]                wd;
		set      = '0;
		clr      = '0;
		wr       = bus.wr;
		wd       = bus.wdata;
		run      = st_r.ctrl[rtcsa_pkg::CTRL_RUN];
		sec_step = 1'b0;
		st_nxt   = st_r;

		// subsecond count and seconds carry; runs in every power mode
		if (run && tick)
		begin
			st_nxt.sub = st_r.sub + 1'b1;
			if (st_r.sub == {rtcsa_pkg::SUB_W{1'b1}})
			begin
				sec_step   = 1'b1;
				st_nxt.sec = st_r.sec + 32'h0000_0001;
			end
		end

		// time-of-day alarm compares the new second against its match value
		if (sec_step && st_r.tod_arm && (st_nxt.sec == st_r.tod_match))
		begin
			if (st_r.ctrl[rtcsa_pkg::CTRL_TOD_EN])
				set[rtcsa_pkg::ST_TOD] = 1'b1;
			if (st_r.ctrl[rtcsa_pkg::CTRL_TOD_RECUR])
				st_nxt.tod_match = st_r.tod_match + st_r.tod_int;
			else
				st_nxt.tod_arm = 1'b0;
		end

		// subsecond alarm counts down whole 1/4096 s ticks
		if (run && tick && st_r.ss_arm)
		begin
			if (st_r.ss_cnt <= 32'h0000_0001)
			begin
				if (st_r.ctrl[rtcsa_pkg::CTRL_SS_EN])
					set[rtcsa_pkg::ST_SS] = 1'b1;
				if (st_r.ctrl[rtcsa_pkg::CTRL_SS_RECUR])
					st_nxt.ss_cnt = st_r.ss_reload;
				else
				begin
					st_nxt.ss_cnt = 32'h0000_0000;
					st_nxt.ss_arm = 1'b0;
				end
			end
			else
				st_nxt.ss_cnt = st_r.ss_cnt - 32'h0000_0001;
		end

		// register writes; a seconds write beats a carry in the same cycle
		if (wr)
		begin
			unique case (bus.addr)
				rtcsa_pkg::OFS_SECONDS:
					st_nxt.sec = wd;
				rtcsa_pkg::OFS_SUBSEC:
					st_nxt.sub = wd[rtcsa_pkg::SUB_W-1:0];
				rtcsa_pkg::OFS_TOD_ALM:
				begin
					// intervals outside the window are refused and flagged
					if (wd >= 32'(rtcsa_pkg::ALM_MIN_S) && wd <= 32'(rtcsa_pkg::ALM_MAX_S))
					begin
						st_nxt.tod_int   = wd;
						st_nxt.tod_match = st_nxt.sec + wd;
						st_nxt.tod_arm   = 1'b1;
					end
					else
					begin
						st_nxt.tod_arm = 1'b0;
						set[rtcsa_pkg::ST_BAD_ALM] = 1'b1;
					end
				end
				rtcsa_pkg::OFS_SS_ALM:
				begin
					st_nxt.ss_reload = wd;
					st_nxt.ss_cnt    = wd;
					st_nxt.ss_arm    = (wd != 32'h0000_0000);
				end
				rtcsa_pkg::OFS_CTRL:
					st_nxt.ctrl = wd[rtcsa_pkg::CTRL_W-1:0];
				rtcsa_pkg::OFS_CAL:
					st_nxt.cal = wd[7:0];
				rtcsa_pkg::OFS_INT_CLR:
					clr = wd[rtcsa_pkg::ST_W-1:0];
				rtcsa_pkg::OFS_INT_EN:
					st_nxt.ien = wd[rtcsa_pkg::ST_W-1:0];
				default:
					st_nxt.ien = st_r.ien;                         // unmapped writes are dropped
			endcase
		end

		// sticky status; hardware set wins over a clear in the same cycle
		st_nxt.stat = rtcsa_pkg::sticky(st_r.stat, set, clr);

		// read data stand for exactly one cycle after the strobe
		st_nxt.rdata = 32'h0000_0000;
		if (bus.rd)
		begin
			unique case (bus.addr)
				rtcsa_pkg::OFS_SECONDS: st_nxt.rdata = st_r.sec;
				rtcsa_pkg::OFS_SUBSEC:  st_nxt.rdata = 32'(st_r.sub);
				rtcsa_pkg::OFS_TOD_ALM: st_nxt.rdata = st_r.tod_int;
				rtcsa_pkg::OFS_SS_ALM:  st_nxt.rdata = st_r.ss_cnt;
				rtcsa_pkg::OFS_CTRL:    st_nxt.rdata = 32'(st_r.ctrl);
				rtcsa_pkg::OFS_CAL:     st_nxt.rdata = 32'(st_r.cal);
				rtcsa_pkg::OFS_STATUS:  st_nxt.rdata = 32'(st_r.stat);
				rtcsa_pkg::OFS_INT_EN:  st_nxt.rdata = 32'(st_r.ien);
				default:                st_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// level interrupt follows the enabled sticky bits; wake request copies it outside active mode
		st_nxt.irq  = |(st_nxt.stat & st_nxt.ien);
		st_nxt.wake = st_nxt.irq && (pmode != rtcsa_pkg::RTCSA_ACTIVE);
	end

	// ************************************************************
	// state register, frozen while ce is low
	// ************************************************************
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_r      <= '0;
			st_r.ctrl <= rtcsa_pkg::CTRL_RST;
			st_r.cal  <= rtcsa_pkg::CAL_RST;
			st_r.ien  <= rtcsa_pkg::IEN_RST;
		end
		else if (ce)
			st_r <= st_nxt;
	end

	// outputs straight from flops
	assign rdata              = st_r.rdata;
	assign irq                = st_r.irq;
	assign wake_req           = st_r.wake;
	assign square_wave_output = sqw;

endmodule : rtcsa_top

// ---- test/rtcsa_assertions.sv ----
// port-level assertion checker for the seconds/subsecond clock
`timescale 1ns/1ps
module rtcsa_checker
(
	// clock and reset
	input wire logic                    mclk,
	input wire logic                    rst,
	input wire logic                    ce,
	// register port
	input wire rtcsa_pkg::rtcsa_bus_t   bus,
	input wire logic [31:0]             rdata,
	// time base, power state and events
	input wire logic                    xtal_in,
	input wire rtcsa_pkg::rtcsa_pmode_t pmode,
	input wire logic                    irq,
	input wire logic                    wake_req,
	input wire logic                    square_wave_output
);
	// ************************************************************
	// port relations, one clock domain
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// read data may only stand in the slot after a read strobe
	rd_idle_a: assert property (ce && !bus.rd |=> rdata == 32'h0)
		else $error("read data outside its slot");
	unmapped_zero_a: assert property (ce && bus.rd && (bus.addr == 8'h24 || bus.addr == rtcsa_pkg::OFS_INT_CLR)
		|=> rdata == 32'h0) else $error("unmapped or clear read not zero");
	status_width_a: assert property (ce && bus.rd && bus.addr == rtcsa_pkg::OFS_STATUS
		|=> rdata[31:3] == 29'h0) else $error("status spare bits set");
	subsec_width_a: assert property (ce && bus.rd && bus.addr == rtcsa_pkg::OFS_SUBSEC
		|=> rdata[31:12] == 20'h0) else $error("subsecond wider than 4096 ticks");
	// wake only as a copy of the interrupt outside active mode
	wake_irq_a: assert property (wake_req |-> irq) else $error("wake without interrupt");
	active_wake_a: assert property (ce && pmode == rtcsa_pkg::RTCSA_ACTIVE |=> !wake_req)
		else $error("wake in active mode");
	// masking every source must drop the interrupt within two edges
	irq_mask_a: assert property (ce && bus.wr && bus.addr == rtcsa_pkg::OFS_INT_EN && bus.wdata[2:0] == 3'h0
		##1 ce |=> !irq) else $error("interrupt high while masked");
	freeze_a: assert property (!ce |=> $stable(square_wave_output) && $stable(irq))
		else $error("outputs moved while clock enable low");
endmodule : rtcsa_checker

bind rtcsa_top rtcsa_checker u_chk (.mclk(mclk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata), .xtal_in(xtal_in),
	.pmode(pmode), .irq(irq), .wake_req(wake_req), .square_wave_output(square_wave_output));

// ---- test/rtcsa_top_tb.sv ----
// self-checking bench for the seconds/subsecond clock
`timescale 1ns/1ps
`define CHK(g, e) #1 check((g), (e))
module rtcsa_top_tb;
	// ************************************************************
	// signals and design
	// ************************************************************
	logic                    mclk;
	logic                    rst;
	logic                    ce;
	rtcsa_pkg::rtcsa_bus_t   bus;
	logic [31:0]             rdata;
	logic                    xtal_in;
	rtcsa_pkg::rtcsa_pmode_t pmode;
	logic                    irq;
	logic                    wake_req;
	logic                    sqw;
	int                      errors;
	int                      comparisons;
	logic [31:0]             seed;
	logic [31:0]             v;

	rtcsa_top dut (.mclk(mclk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata), .xtal_in(xtal_in), .pmode(pmode),
		.irq(irq), .wake_req(wake_req), .square_wave_output(sqw));

	// 100 MHz clock
	always #5 mclk = ~mclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : check

	// bus cycles: strobes drop one edge later, so tasks never collide
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		`CHK(rdata, e);
	endtask : rc

	// n time-base edges, then let the tick ripple through
	task automatic xt(input int n);
		repeat (n)
		begin
			@(posedge mclk);
			xtal_in <= 1'b1;
			@(posedge mclk);
			xtal_in <= 1'b0;
		end
		repeat (4) @(posedge mclk);
	endtask : xt

	task automatic tally_and_finish;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// watchdog: the whole run needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge mclk);
		errors++;
		tally_and_finish();
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial
	begin
		mclk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		bus = '0;
		xtal_in = 1'b0;
		pmode = rtcsa_pkg::RTCSA_ACTIVE;
		seed = 32'h7C572CC6;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rc(rtcsa_pkg::OFS_CTRL, 32'h1);
		rc(rtcsa_pkg::OFS_SECONDS, 32'h0);
		rc(rtcsa_pkg::OFS_STATUS, 32'h0);
		rc(8'h24, 32'h0);
		$display("test reset done");
		// load, freeze and carry in every power mode; first pass wraps 32 bits
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			v = (i == 0) ? 32'hFFFFFFFF : seed;
			pmode <= rtcsa_pkg::rtcsa_pmode_t'(i[1:0]);
			wr(rtcsa_pkg::OFS_SECONDS, v);
			rc(rtcsa_pkg::OFS_SECONDS, v);
			wr(rtcsa_pkg::OFS_SUBSEC, 32'hFFF);
			xt(8);
			ce <= 1'b0;
			repeat (3) @(posedge mclk);
			ce <= 1'b1;
			rc(rtcsa_pkg::OFS_SECONDS, v + 32'h1);
			rc(rtcsa_pkg::OFS_SUBSEC, 32'h0);
		end
		$display("test carry done");
		// refused intervals either side of the legal span, then the far edge
		pmode <= rtcsa_pkg::RTCSA_ACTIVE;
		wr(rtcsa_pkg::OFS_INT_EN, 32'h5);
		for (int i = 0; i < 2; i++)
		begin
			wr(rtcsa_pkg::OFS_TOD_ALM, i ? 32'd1036801 : 32'h0);
			rc(rtcsa_pkg::OFS_STATUS, 32'h4);
			`CHK(irq, 1'b1);
			wr(rtcsa_pkg::OFS_INT_CLR, 32'h4);
		end
		wr(rtcsa_pkg::OFS_TOD_ALM, 32'd1036800);
		rc(rtcsa_pkg::OFS_STATUS, 32'h0);
		// one-second recurring alarm fires on two carries running
		wr(rtcsa_pkg::OFS_TOD_ALM, 32'h1);
		wr(rtcsa_pkg::OFS_CTRL, 32'hB);
		for (int i = 0; i < 2; i++)
		begin
			wr(rtcsa_pkg::OFS_SUBSEC, 32'hFFF);
			xt(8);
			rc(rtcsa_pkg::OFS_STATUS, 32'h1);
			`CHK(wake_req, 1'b0);
			wr(rtcsa_pkg::OFS_INT_CLR, 32'h1);
		end
		wr(rtcsa_pkg::OFS_INT_EN, 32'h0);
		$display("test day alarm done");
		// recurring subsecond alarm of three ticks while asleep, then in backup
		pmode <= rtcsa_pkg::RTCSA_SLEEP;
		wr(rtcsa_pkg::OFS_INT_CLR, 32'h7);
		wr(rtcsa_pkg::OFS_INT_EN, 32'h2);
		wr(rtcsa_pkg::OFS_CTRL, 32'h15);
		wr(rtcsa_pkg::OFS_SS_ALM, 32'h3);
		xt(16);
		rc(rtcsa_pkg::OFS_STATUS, 32'h0);
		xt(8);
		rc(rtcsa_pkg::OFS_STATUS, 32'h2);
		`CHK(wake_req, 1'b1);
		wr(rtcsa_pkg::OFS_INT_CLR, 32'h2);
		rc(rtcsa_pkg::OFS_STATUS, 32'h0);
		pmode <= rtcsa_pkg::RTCSA_BACKUP;
		xt(24);
		rc(rtcsa_pkg::OFS_STATUS, 32'h2);
		`CHK(wake_req, 1'b1);
		wr(rtcsa_pkg::OFS_INT_EN, 32'h0);
		pmode <= rtcsa_pkg::RTCSA_ACTIVE;
		$display("test subsecond alarm done");
		// square wave: half a period every four edges, silent once switched off
		wr(rtcsa_pkg::OFS_CTRL, 32'h21);
		for (int i = 0; i < 4; i++)
		begin
			xt(4);
			`CHK(sqw, {31'h0, !i[0]});
		end
		xt(4);
		`CHK(sqw, 1'b1);
		// turned off while high: must drop, not hold its last level
		wr(rtcsa_pkg::OFS_CTRL, 32'h1);
		repeat (2) @(posedge mclk);
		`CHK(sqw, 1'b0);
		// signed trim register read back at -127 and +127 of its -128 to +127 range
		wr(rtcsa_pkg::OFS_CAL, 32'h81);
		rc(rtcsa_pkg::OFS_CAL, 32'h81);
		wr(rtcsa_pkg::OFS_CAL, 32'h7F);
		rc(rtcsa_pkg::OFS_CAL, 32'h7F);
		$display("test wave and trim done");
		tally_and_finish();
	end
endmodule : rtcsa_top_tb
